// ===== rtl/obd_bank_ctrl.sv
// bank C output divider control registers and setting selection
`timescale 1ns/1ps

module obd_bank_ctrl
(
   input wire logic clk,
   input wire logic rst,
   input wire obd_pkg::obd_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   input wire obd_pkg::obd_cfg_t pin_cfg,
   input wire logic init_clk,
   output obd_pkg::obd_cfg_t bank_cfg,
   output logic [5:0] active_code,
   output logic [7:0] active_ratio,
   output logic divider_restart
);
   import obd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      obd_cfg_t regs;
      logic cfg_src;
      logic [7:0] rdata;
      logic rvalid;
      logic init_prev;
      obd_cfg_t cfg_out;
      logic [5:0] act_code;
      logic [7:0] act_ratio;
      logic restart;
   } obd_state_t;

   obd_state_t st_r;
   obd_state_t st_nxt;
   obd_cfg_t sel_cfg;
   logic init_toggle;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;
      st_nxt.restart = 1'b0;

      // register writes; reserved bits are dropped, not stored
      if (req.wr_en)
      begin
         case (req.addr)
            OBD_ADDR_DIV: st_nxt.regs.div_code = req.wdata[OBD_DIV_MSB:OBD_DIV_LSB];
            OBD_ADDR_PWR_SRC:
            begin
               st_nxt.regs.bank_pd = req.wdata[OBD_BANK_PD_BIT];
               st_nxt.cfg_src = req.wdata[OBD_SRC_BIT];
            end
            default:
            begin
            end
         endcase
         for (int i = 0; i < OBD_NUM_OUT; i++)
         begin
            if (req.addr == OBD_ADDR_OUT0 + 8'(i))
            begin
               st_nxt.regs.out_pd[i] = req.wdata[OBD_OUT_PD_BIT];
               st_nxt.regs.style[i] = req.wdata[OBD_STYLE_BIT];
               st_nxt.regs.amp[i] = req.wdata[OBD_AMP_MSB:OBD_AMP_LSB];
            end
         end
      end

      // reads; reserved bits and unmapped addresses return zero
      if (req.rd_en)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = OBD_ZERO_BYTE;
         case (req.addr)
            OBD_ADDR_DIV: st_nxt.rdata[OBD_DIV_MSB:OBD_DIV_LSB] = st_r.regs.div_code;
            OBD_ADDR_PWR_SRC:
            begin
               st_nxt.rdata[OBD_BANK_PD_BIT] = st_r.regs.bank_pd;
               st_nxt.rdata[OBD_SRC_BIT] = st_r.cfg_src;
            end
            default:
            begin
            end
         endcase
         for (int i = 0; i < OBD_NUM_OUT; i++)
         begin
            if (req.addr == OBD_ADDR_OUT0 + 8'(i))
            begin
               st_nxt.rdata[OBD_OUT_PD_BIT] = st_r.regs.out_pd[i];
               st_nxt.rdata[OBD_STYLE_BIT] = st_r.regs.style[i];
               st_nxt.rdata[OBD_AMP_MSB:OBD_AMP_LSB] = st_r.regs.amp[i];
            end
         end
      end

      // source select: pin-decoded settings or register contents
      sel_cfg = st_r.cfg_src ? st_r.regs : pin_cfg;

      // power-down, style and amplitude follow the selected source at once
      st_nxt.cfg_out = sel_cfg;

      // the ratio only moves on an init toggle, so a half-written setup
      // never reaches the divider
      st_nxt.init_prev = init_clk;
      init_toggle = init_clk ^ st_r.init_prev;
      if (init_toggle)
      begin
         st_nxt.act_code = sel_cfg.div_code;
         st_nxt.act_ratio = obd_ratio(sel_cfg.div_code);
         st_nxt.restart = 1'b1;
      end
      // the reported code moves in the same cycle as active_code, never a cycle late
      st_nxt.cfg_out.div_code = st_nxt.act_code;
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_r.regs.div_code <= OBD_DIV_RST;
         st_r.regs.bank_pd <= OBD_BIT_RST;
         st_r.regs.out_pd <= {OBD_NUM_OUT{OBD_BIT_RST}};
         st_r.regs.style <= {OBD_NUM_OUT{OBD_STYLE_LVDS}};
         st_r.regs.amp <= {OBD_NUM_OUT{OBD_AMP_RST}};
         st_r.cfg_src <= OBD_BIT_RST;
         st_r.rdata <= OBD_ZERO_BYTE;
         st_r.rvalid <= 1'b0;
         st_r.init_prev <= 1'b0;
         st_r.cfg_out.div_code <= OBD_DIV_RST;
         st_r.cfg_out.bank_pd <= OBD_BIT_RST;
         st_r.cfg_out.out_pd <= {OBD_NUM_OUT{OBD_BIT_RST}};
         st_r.cfg_out.style <= {OBD_NUM_OUT{OBD_STYLE_LVDS}};
         st_r.cfg_out.amp <= {OBD_NUM_OUT{OBD_AMP_RST}};
         st_r.act_code <= OBD_DIV_RST;
         st_r.act_ratio <= obd_ratio(OBD_DIV_RST);
         st_r.restart <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign rdata = st_r.rdata;
   assign rvalid = st_r.rvalid;
   assign bank_cfg = st_r.cfg_out;
   assign active_code = st_r.act_code;
   assign active_ratio = st_r.act_ratio;
   assign divider_restart = st_r.restart;

endmodule // obd_bank_ctrl

// ===== rtl/obd_pkg.sv
// package for the bank C output divider control register block
package obd_pkg;

   localparam logic [7:0] OBD_ADDR_DIV = 8'h20;
   localparam logic [7:0] OBD_ADDR_RSV_A = 8'h21;
   localparam logic [7:0] OBD_ADDR_PWR_SRC = 8'h22;
   localparam logic [7:0] OBD_ADDR_RSV_B = 8'h23;
   localparam logic [7:0] OBD_ADDR_OUT0 = 8'h24;
   localparam logic [7:0] OBD_ADDR_OUT1 = 8'h25;
   localparam logic [7:0] OBD_ADDR_RSV_C = 8'h26;
   localparam logic [7:0] OBD_ADDR_RSV_D = 8'h27;

   // field positions
   localparam int OBD_DIV_LSB = 0;
   localparam int OBD_DIV_MSB = 5;
   localparam int OBD_BANK_PD_BIT = 7;
   localparam int OBD_SRC_BIT = 0;
   localparam int OBD_OUT_PD_BIT = 7;
   localparam int OBD_STYLE_BIT = 2;
   localparam int OBD_AMP_LSB = 0;
   localparam int OBD_AMP_MSB = 1;
   localparam int OBD_NUM_OUT = 2;

   // reset values
   localparam logic [5:0] OBD_DIV_RST = 6'h0D;
   localparam logic OBD_BIT_RST = 1'b0;
   localparam logic [1:0] OBD_AMP_RST = 2'h0;
   localparam logic [7:0] OBD_ZERO_BYTE = 8'h00;

   // output style and amplitude codes
   localparam logic OBD_STYLE_LVDS = 1'b0;
   localparam logic OBD_STYLE_LVPECL = 1'b1;
   localparam logic [1:0] OBD_AMP_350MV = 2'h0;
   localparam logic [1:0] OBD_AMP_500MV = 2'h1;
   localparam logic [1:0] OBD_AMP_750MV = 2'h2;
   localparam logic [1:0] OBD_AMP_RSVD = 2'h3;

   // one bank's settings, from pins or from registers
   typedef struct packed {
      logic [5:0] div_code;
      logic bank_pd;
      logic [OBD_NUM_OUT-1:0] out_pd;
      logic [OBD_NUM_OUT-1:0] style;
      logic [OBD_NUM_OUT-1:0][1:0] amp;
   } obd_cfg_t;

   // byte register port from the serial interface engine
   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } obd_req_t;

   // divide ratio per code; 0 marks a reserved or unresolved code
   function automatic logic [7:0] obd_ratio(input logic [5:0] code);
      logic [7:0] r;
      r = 8'h00;
      case (code)
         6'h01: r = 8'd1;
         6'h02: r = 8'd2;
         6'h03: r = 8'd3;
         6'h04: r = 8'd4;
         6'h05: r = 8'd5;
         6'h06: r = 8'd6;
         6'h07: r = 8'd8;
         6'h08: r = 8'd9;
         6'h09: r = 8'd10;
         6'h0A: r = 8'd12;
         6'h0C: r = 8'd15;
         6'h0D: r = 8'd16;
         6'h0E: r = 8'd18;
         6'h0F: r = 8'd20;
         6'h10: r = 8'd21;
         6'h11: r = 8'd22;
         6'h12: r = 8'd24;
         6'h13: r = 8'd25;
         6'h14: r = 8'd27;
         6'h15: r = 8'd28;
         6'h16: r = 8'd30;
         6'h17: r = 8'd32;
         6'h18: r = 8'd33;
         6'h19: r = 8'd35;
         6'h1A: r = 8'd36;
         6'h1B: r = 8'd40;
         6'h1C: r = 8'd42;
         6'h1D: r = 8'd44;
         6'h1E: r = 8'd45;
         6'h1F: r = 8'd48;
         6'h20: r = 8'd50;
         6'h21: r = 8'd54;
         6'h22: r = 8'd55;
         6'h23: r = 8'd56;
         6'h24: r = 8'd60;
         6'h25: r = 8'd64;
         6'h26: r = 8'd66;
         6'h27: r = 8'd70;
         6'h28: r = 8'd72;
         6'h29: r = 8'd80;
         6'h2A: r = 8'd84;
         6'h2B: r = 8'd88;
         6'h2C: r = 8'd90;
         6'h2D: r = 8'd96;
         6'h2E: r = 8'd100;
         6'h2F: r = 8'd108;
         6'h30: r = 8'd112;
         6'h32: r = 8'd120;
         6'h33: r = 8'd128;
         6'h34: r = 8'd132;
         6'h35: r = 8'd140;
         6'h36: r = 8'd144;
         6'h37: r = 8'd160;
         6'h38: r = 8'd176;
         6'h39: r = 8'd180;
         6'h3A: r = 8'd200;
         6'h3B: r = 8'd220;
         default: r = 8'h00;
      endcase
      return r;
   endfunction

endpackage

// ===== test/obd_bank_ctrl_props.sv
// concurrent checks on the bank C divider control ports
`timescale 1ns/1ps
module obd_bank_ctrl_chk
(
   input wire logic clk,
   input wire logic rst,
   input wire obd_pkg::obd_req_t req,
   input wire logic rvalid,
   input wire logic init_clk,
   input wire obd_pkg::obd_cfg_t bank_cfg,
   input wire logic [5:0] active_code,
   input wire logic [7:0] active_ratio,
   input wire logic divider_restart
);
   import obd_pkg::*;
   logic prev_r;
   // mirrors the design's init history so a high level at release counts as a toggle
   always_ff @(posedge clk)
      prev_r <= rst ? 1'b0 : init_clk;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence toggled;
      init_clk != prev_r;
   endsequence
   sequence steady;
      init_clk == prev_r;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   chk_read_answer: assert property (req.rd_en |=> rvalid)
      else $error("read without answer");
   chk_read_quiet: assert property (!req.rd_en |=> !rvalid)
      else $error("answer without read");
   chk_restart_pulse: assert property (toggled |=> divider_restart)
      else $error("toggle without restart");
   chk_restart_only: assert property (steady |=> !divider_restart)
      else $error("restart without toggle");
   chk_code_hold: assert property (steady |=> $stable(active_code))
      else $error("active code moved");
   chk_div_mirror: assert property (bank_cfg.div_code == active_code)
      else $error("bank code differs");
   chk_ratio_one: assert property (active_code == 6'h01 |-> active_ratio == 8'h01)
      else $error("unity ratio wrong");
   chk_ratio_top: assert property (active_code == 6'h3B |-> active_ratio == 8'hDC)
      else $error("top ratio wrong");
endmodule // obd_bank_ctrl_chk
bind obd_bank_ctrl obd_bank_ctrl_chk chk_i (.clk, .rst, .req, .rvalid, .init_clk, .bank_cfg,
   .active_code, .active_ratio, .divider_restart);

// ===== test/obd_host_model.sv
// serial host and bank pin model for the divider control block
`timescale 1ns/1ps
module obd_host_model
(
   input wire logic clk,
   output obd_pkg::obd_req_t req,
   output obd_pkg::obd_cfg_t pin_cfg,
   output logic init_clk,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   import obd_pkg::*;
   initial
   begin
      req = '0;
      pin_cfg = '0;
      init_clk = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, d & m};
      @(posedge clk);
      req.wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      req.rd_en <= 1'b0;
      #1;
      d = rdata;
      v = rvalid;
   endtask
   task automatic toggle();
      @(posedge clk);
      init_clk <= ~init_clk;
      @(posedge clk);
      #1;
   endtask
endmodule // obd_host_model

// ===== test/tb.sv
// self-checking bench for the bank C divider control registers
`timescale 1ns/1ps
module tb;
   import obd_pkg::*;
   logic clk, rst, init_clk, rvalid, divider_restart, v;
   obd_req_t req;
   obd_cfg_t pin_cfg, bank_cfg, p;
   logic [7:0] rdata, active_ratio, d;
   logic [5:0] active_code;
   logic [31:0] seed = 32'h41DFF6C3;
   logic [5:0] codes [5] = '{6'h01, 6'h0D, 6'h2F, 6'h3B, 6'h00};
   int num_errors = 0, checks = 0, cyc = 0;
   obd_host_model host (.clk, .req, .pin_cfg, .init_clk, .rdata, .rvalid);
   obd_bank_ctrl uut (.clk, .rst, .req, .rdata, .rvalid, .pin_cfg, .init_clk, .bank_cfg,
      .active_code, .active_ratio, .divider_restart);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] exp_ratio(input logic [5:0] c);
      case (c)
         6'h01: return 8'h01;
         6'h0D: return 8'h10;
         6'h2F: return 8'h6C;
         6'h3B: return 8'hDC;
         default: return 8'h00;
      endcase
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, d, v);
      chk({v, d}, {1'b1, e});
   endtask
   task automatic results();
      $display("errors=%0d checks=%0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // the whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 3000)
      begin
         num_errors++;
         results();
      end
   end
   initial
   begin
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk({active_code, active_ratio}, {6'h0D, 8'h10});
      rchk(OBD_ADDR_DIV, 8'h0D);
      for (int i = 1; i < 8; i++)
         rchk(OBD_ADDR_DIV + i[7:0], 8'h00);
      rchk(8'h30, 8'h00);
      seed = lfsr(seed);
      p = seed[$bits(p)-1:0];
      host.pin_cfg <= p;
      repeat (2) @(posedge clk);
      #1;
      chk(bank_cfg[8:0], p[8:0]);
      host.toggle();
      chk({active_code, divider_restart}, {p.div_code, 1'b1});
      seed = lfsr(seed);
      host.wr(OBD_ADDR_DIV, seed[7:0], 8'h3F);
      rchk(OBD_ADDR_DIV, seed[7:0] & 8'h3F);
      chk(active_code, p.div_code);
      host.wr(OBD_ADDR_PWR_SRC, 8'h81, 8'h81);
      host.wr(OBD_ADDR_OUT0, 8'h85, 8'h87);
      host.wr(OBD_ADDR_OUT1, 8'h86, 8'h87);
      repeat (2) @(posedge clk);
      #1;
      chk(bank_cfg[8:0], 9'b1_11_11_10_01);
      rchk(OBD_ADDR_OUT1, 8'h86);
      foreach (codes[k])
      begin
         host.wr(OBD_ADDR_DIV, {2'b00, codes[k]}, 8'h3F);
         host.toggle();
         chk({active_code, active_ratio}, {codes[k], exp_ratio(codes[k])});
         chk(bank_cfg.div_code, codes[k]);
      end
      results();
   end
endmodule // tb
